// *** rtl/pvc_top.v ***
// Control, timing and gain readback for the pin volume converter.
`timescale 1ns/1ps
`include "pvc_defines.vh"
// Function
// R1 - Bit 7 picks pin or register volume and register mode stops the SAR.
// R2 - Clock select 0 uses the RC oscillator ticks, 1 the master clock ticks.
// R3 - A 2-bit hysteresis field holds the result within one or two LSBs.
// R4 - A 3-bit rate field sets throughput, doubling it for each code step.
// R5 - Oscillator rates use the same division and scale with its frequency.
// R6 - The 7-bit gain report is 18 dB at zero and 0.5 dB lower per step.
// R7 - Codes 1011011 up step 1 dB to -63 dB; 1111111 is never reported.
// R8 - The host avoids reserved registers and leaves reserved bits at reset.
// R9 - An 8-bit page register selects pages 0 to 255 and resets to page 0.
// R10 - The gain report changes only when a conversion ends, past hysteresis; the first after reset or pin mode entry is always taken.
module pvc_top #(
    parameter BASE_DIV = `PVC_BASE_DIV
) (
    // Clock and reset
    input wire clk_in,
    input wire reset_n_in,
    // Register port
    input wire [6:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    output reg reg_rvalid_out,
    // Converter clock sources, one-cycle enables
    input wire osc_tick_in,
    input wire mclk_tick_in,
    // Analog converter on the volume detect pin
    input wire volume_detect_pin_cmp_in,
    output wire [6:0] volume_detect_pin_trial_out,
    output reg sar_power_out,
    output wire conv_done_out,
    // Volume steering towards the DAC
    output reg [7:0] page_out,
    output reg volume_from_pin_out,
    output reg [6:0] pin_gain_out
);

////////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] page_select;
reg [7:0] volume_converter_control;
reg gain_valid;

wire page0 = (page_select == 8'h00);
wire pin_mode = volume_converter_control[`PVC_BIT_PIN_MODE];
wire clk_sel = volume_converter_control[`PVC_BIT_CLK_SEL];
wire [1:0] hys = volume_converter_control[`PVC_HYS_HI:`PVC_HYS_LO];
wire [2:0] rate = volume_converter_control[`PVC_RATE_HI:`PVC_RATE_LO];

// Page control is reachable on every page, the converter pair on page 0.
function [1:0] pvc_decode;
    input [6:0] addr;
    input on_page0;
    begin
        if (addr == `PVC_OFS_PAGE) begin
            pvc_decode = 2'h1;
        end else if (on_page0 && addr == `PVC_OFS_VCTRL) begin
            pvc_decode = 2'h2;
        end else if (on_page0 && addr == `PVC_OFS_GAIN) begin
            pvc_decode = 2'h3;
        end else begin
            pvc_decode = 2'h0;
        end
    end
endfunction

wire [1:0] wr_sel = pvc_decode(reg_addr_in, page0);

// Reserved locations and the gain register take writes without effect.
always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        page_select <= `PVC_RST_PAGE; // [R9]
        volume_converter_control <= `PVC_RST_VCTRL;
    end else if (reg_wr_in) begin
        if (wr_sel == 2'h1) begin
            page_select <= reg_wdata_in; // [R9]
        end else if (wr_sel == 2'h2) begin
            volume_converter_control <= reg_wdata_in; // [R8]
        end
    end
end

always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        reg_rdata_out <= 8'h00;
        reg_rvalid_out <= 1'b0;
    end else begin
        reg_rvalid_out <= reg_rd_in;
        if (reg_rd_in) begin
            case (wr_sel)
                2'h1: reg_rdata_out <= page_select;
                2'h2: reg_rdata_out <= volume_converter_control;
                2'h3: reg_rdata_out <= {1'b0, pin_gain_out}; // [R6]
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Conversion timing

wire src_tick = clk_sel ? mclk_tick_in : osc_tick_in; // [R2]
wire [19:0] base = BASE_DIV[19:0];
wire [19:0] period = base >> rate; // [R4] [R5]
reg [19:0] div_cnt;
wire conv_start = src_tick && (div_cnt >= period - 20'h1);
wire [6:0] sar_result;

// The divider and converter stop while register control is chosen.
always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        div_cnt <= 20'h0;
        sar_power_out <= 1'b0;
        volume_from_pin_out <= 1'b0;
        page_out <= `PVC_RST_PAGE;
    end else begin
        sar_power_out <= pin_mode; // [R1]
        volume_from_pin_out <= pin_mode; // [R1]
        page_out <= page_select;
        if (!pin_mode) begin
            div_cnt <= 20'h0; // [R1]
        end else if (src_tick) begin
            div_cnt <= conv_start ? 20'h0 : div_cnt + 20'h1; // [R4]
        end
    end
end

pvc_sar pvc_sar_inst (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .start_in(conv_start && pin_mode),
    .step_in(src_tick && pin_mode),
    .cmp_in(volume_detect_pin_cmp_in),
    .trial_out(volume_detect_pin_trial_out),
    .result_out(sar_result),
    .done_out(conv_done_out),
    .busy_out()
);

////////////////////////////////////////////////////////////////////////////
// Hysteresis and gain report

wire [6:0] clamped = (sar_result == `PVC_GAIN_RESERVED) ?
                     `PVC_GAIN_LOWEST : sar_result; // [R7]
wire [6:0] diff = (clamped > pin_gain_out) ? clamped - pin_gain_out :
                  pin_gain_out - clamped;
reg [6:0] band;

always @* begin
    if (hys == `PVC_HYS_ONE) begin
        band = 7'h01; // [R3]
    end else if (hys == `PVC_HYS_TWO) begin
        band = 7'h02; // [R3]
    end else begin
        band = 7'h00;
    end
end

wire take = !gain_valid || (diff > band); // [R3]

always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        pin_gain_out <= `PVC_RST_GAIN;
        gain_valid <= 1'b0;
    end else if (!pin_mode) begin
        gain_valid <= 1'b0;
    end else if (conv_done_out && take) begin
        pin_gain_out <= clamped; // [R10] [R6]
        gain_valid <= 1'b1;
    end
end

endmodule

// *** rtl/pvc_defines.vh ***
// Constants for the pin volume control converter block.
`ifndef PVC_DEFINES_VH
`define PVC_DEFINES_VH
// Register offsets within a page.
`define PVC_OFS_PAGE 7'h00
`define PVC_OFS_VCTRL 7'h74
`define PVC_OFS_GAIN 7'h75
// Reset values.
`define PVC_RST_PAGE 8'h00
`define PVC_RST_VCTRL 8'h00
`define PVC_RST_GAIN 7'h00
// Field positions in the converter control register.
`define PVC_BIT_PIN_MODE 7
`define PVC_BIT_CLK_SEL 6
`define PVC_HYS_HI 5
`define PVC_HYS_LO 4
`define PVC_RATE_HI 2
`define PVC_RATE_LO 0
// Hysteresis codes.
`define PVC_HYS_ONE 2'h1
`define PVC_HYS_TWO 2'h2
// Gain codes.
`define PVC_GAIN_RESERVED 7'h7f
`define PVC_GAIN_LOWEST 7'h7e
// Source clock edges per conversion at the slowest rate code.
`define PVC_BASE_DIV 768000
// Successive approximation start mask, the MSB of the 7-bit converter.
`define PVC_SAR_MSB 7'h40
`endif

// *** rtl/pvc_sar.v ***
// Successive approximation sequencer for the 7-bit volume converter.
`timescale 1ns/1ps
`include "pvc_defines.vh"
module pvc_sar (
    // Clock and reset
    input wire clk_in,
    input wire reset_n_in,
    // Control
    input wire start_in,
    input wire step_in,
    input wire cmp_in,
    // Results
    output reg [6:0] trial_out,
    output reg [6:0] result_out,
    output reg done_out,
    output wire busy_out
);

reg [6:0] mask;

assign busy_out = |mask;

// One bit is decided per source clock edge, most significant first.
always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        mask <= 7'h00;
        trial_out <= 7'h00;
        result_out <= 7'h00;
        done_out <= 1'b0;
    end else begin
        done_out <= 1'b0;
        if (start_in && !busy_out) begin
            mask <= `PVC_SAR_MSB;
            trial_out <= `PVC_SAR_MSB;
        end else if (busy_out && step_in) begin
            mask <= mask >> 1;
            if (mask == 7'h01) begin
                result_out <= cmp_in ? trial_out : (trial_out & ~mask);
                done_out <= 1'b1;
                trial_out <= 7'h00;
            end else begin
                trial_out <= (cmp_in ? trial_out : (trial_out & ~mask))
                             | (mask >> 1);
            end
        end
    end
end

endmodule

// *** testbench/pvc_pin_model.sv ***
// Volume voltage on the detect pin seen through an ideal comparator.
`timescale 1ns/1ps
module pvc_pin_model (
    // Trial code and pin level
    input wire [6:0] trial_in,
    input wire [6:0] level_in,
    // Comparator answer
    output wire cmp_out
);
    assign cmp_out = level_in >= trial_in;
endmodule

// *** testbench/pvc_top_assertions.sv ***
// Port checker for the pin volume converter.
`timescale 1ns/1ps
module pvc_chk (
    // Watched ports
    input wire clk_in,
    input wire reset_n_in,
    input wire [6:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_rvalid_out,
    input wire [6:0] volume_detect_pin_trial_out,
    input wire sar_power_out,
    input wire conv_done_out,
    input wire [7:0] page_out,
    input wire volume_from_pin_out,
    input wire [6:0] pin_gain_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    a_power_mode: assert property (
        sar_power_out == volume_from_pin_out)
        else $error("power and mode differ");
    a_off_holds: assert property (!sar_power_out [*2] |->
        $stable(pin_gain_out)) else $error("gain moved while off");
    a_gain_legal: assert property (pin_gain_out != 7'h7f)
        else $error("reserved gain code");
    a_gain_cause: assert property (!$stable(pin_gain_out) |->
        $past(conv_done_out)) else $error("gain moved without done");
    a_read_answer: assert property (
        reg_rvalid_out == $past(reg_rd_in))
        else $error("read answer late");
    a_page_write: assert property (reg_wr_in && reg_addr_in == 7'h00
        ##1 !reg_wr_in |=> page_out == $past(reg_wdata_in, 2))
        else $error("page not taken");
    a_done_trial: assert property (conv_done_out |->
        volume_detect_pin_trial_out == 7'h00) else $error("trial not idle");
    a_done_pulse: assert property (conv_done_out |=> !conv_done_out)
        else $error("done too long");
    c_conv: cover property (conv_done_out);
    c_page: cover property (page_out == 8'hff);
    c_off: cover property ($fell(sar_power_out));
endmodule
bind pvc_top pvc_chk pvc_chk_inst (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rvalid_out(reg_rvalid_out),
    .volume_detect_pin_trial_out(volume_detect_pin_trial_out),
    .sar_power_out(sar_power_out),
    .conv_done_out(conv_done_out),
    .page_out(page_out),
    .volume_from_pin_out(volume_from_pin_out),
    .pin_gain_out(pin_gain_out)
);

// *** testbench/pvc_top_bench.sv ***
// Self-checking bench for the pin volume converter.
`timescale 1ns/1ps
module pvc_top_bench;
    reg clk_in = 0, reset_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
    reg osc_tick_in = 0, mclk_tick_in = 1;
    reg [6:0] reg_addr_in = 0, level = 0;
    reg [7:0] reg_wdata_in = 0;
    wire volume_detect_pin_cmp_in, reg_rvalid_out, sar_power_out;
    wire conv_done_out, volume_from_pin_out;
    wire [7:0] reg_rdata_out, page_out;
    wire [6:0] volume_detect_pin_trial_out, pin_gain_out;
    int n_errors = 0, comparisons = 0, t, t7, cyc = 0;
    pvc_top #(.BASE_DIV(1024)) pvc_top_inst (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out),
        .osc_tick_in(osc_tick_in),
        .mclk_tick_in(mclk_tick_in),
        .volume_detect_pin_cmp_in(volume_detect_pin_cmp_in),
        .volume_detect_pin_trial_out(volume_detect_pin_trial_out),
        .sar_power_out(sar_power_out),
        .conv_done_out(conv_done_out),
        .page_out(page_out),
        .volume_from_pin_out(volume_from_pin_out),
        .pin_gain_out(pin_gain_out)
    );
    pvc_pin_model pvc_pin_model_inst (.trial_in(volume_detect_pin_trial_out),
        .level_in(level), .cmp_out(volume_detect_pin_cmp_in));
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input [7:0] seen, input [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wreg(input [6:0] a, input [7:0] d);
        @(posedge clk_in);
        #1 reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1;
        @(posedge clk_in);
        #1 reg_wr_in = 0;
    endtask
    task rreg(input [6:0] a, input [7:0] e, input string what);
        @(posedge clk_in);
        #1 reg_addr_in = a;
        reg_rd_in = 1;
        @(posedge clk_in);
        #1 reg_rd_in = 0;
        check({7'h00, reg_rvalid_out}, 8'h01, "rvalid");
        check(reg_rdata_out, e, what);
    endtask
    // Counts edges up to the next completed conversion.
    task wd();
        t = 0;
        @(posedge clk_in);
        #1;
        repeat (300) if (conv_done_out !== 1'b1) begin
            @(posedge clk_in);
            #1 t++;
        end
    endtask
    // The first pulse may belong to a conversion begun at the old level.
    task conv(input [6:0] lv, input [6:0] e);
        level = lv;
        wd();
        wd();
        @(posedge clk_in);
        #1 check({1'b0, pin_gain_out}, {1'b0, e}, "gain");
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            finish_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_in);
        #1 reset_n_in = 1;
        rreg(7'h00, 8'h00, "page");
        rreg(7'h74, 8'h00, "ctrl");
        wreg(7'h00, 8'hff);
        rreg(7'h00, 8'hff, "page");
        check(page_out, 8'hff, "page_out");
        rreg(7'h74, 8'h00, "ctrl off page");
        wreg(7'h00, 8'h00);
        wreg(7'h74, 8'hc7);
        conv(7'h23, 7'h23);
        check(volume_from_pin_out, 8'h01, "pin mode");
        rreg(7'h75, 8'h23, "gain reg");
        conv(7'h7f, 7'h7e);
        wd();
        wd();
        t7 = t;
        wreg(7'h74, 8'hc6);
        wd();
        wd();
        check(t - t7, 8'h08, "rate step");
        wreg(7'h74, 8'hd7);
        conv(7'h7d, 7'h7e);
        conv(7'h7c, 7'h7c);
        wreg(7'h74, 8'he7);
        conv(7'h7e, 7'h7c);
        wreg(7'h74, 8'h87);
        rreg(7'h74, 8'h87, "ctrl");
        level = 7'h10;
        repeat (100) @(posedge clk_in);
        #1 check({1'b0, pin_gain_out}, 8'h7c, "no osc");
        osc_tick_in = 1;
        conv(7'h10, 7'h10);
        wreg(7'h74, 8'h07);
        level = 7'h30;
        repeat (100) @(posedge clk_in);
        #1 check({1'b0, pin_gain_out}, 8'h10, "held");
        check(sar_power_out, 8'h00, "power");
        finish_test;
    end
endmodule
